// File: rtl/window_comparator_alert_regs.sv
// Purpose: register bank and alert logic of a two-channel window comparator
// Assumes: classic wishbone slave, word index = adr[9:2], data in low byte
// Notes:   ack one cycle after request; unmapped reads return zero
`timescale 1ns/1ps
module window_comparator_alert_regs (
   input  wire logic        i_mclk,
   input  wire logic        i_rst_n,
   input  wire logic        i_ce,
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [31:0] i_wb_adr,
   input  wire logic [3:0]  i_wb_sel,
   input  wire logic [31:0] i_wb_dat,
   output logic      [31:0] o_wb_dat,
   output logic             o_wb_ack,
   input  wire logic        i_sample_vld,
   input  wire logic        i_sample_ch,
   input  wire logic [11:0] i_sample,
   input  wire logic [11:0] i_ch0_high_thr,
   input  wire logic [11:0] i_ch0_low_thr,
   input  wire logic [5:0]  i_ch0_hyst,
   input  wire logic [11:0] i_ch1_high_thr,
   output logic             o_alert,
   output logic             o_irq
);
   logic [7:0] lth_lo_ff;
   logic [7:0] lth_hi_ff;
   logic [7:0] hys_ff;
   logic [7:0] cnt_ff;
   logic [7:0] en_ff;
   logic [1:0] alert_en_ff;
   logic [1:0] low_flags_ff;
   logic [1:0] high_flags_ff;
   logic [3:0] chid_ff;
   logic       chid_set_ff;
   logic [3:0] irq_stat_ff;
   logic [3:0] irq_mask_ff;
   logic       ack_ff;
   logic [7:0] rdat_ff;

   wca_cmp_if cmp0 ();
   wca_cmp_if cmp1 ();

   logic [7:0] idx;
   logic       req;
   logic       wr;
   logic [7:0] wb;
   logic       gen_call;
   logic       seq_go;
   logic [1:0] new_low;
   logic [1:0] new_high;
   logic [1:0] ch_alert;
   logic       any_alert;
   logic [3:0] irq_ev;
   logic [4:0] persist;
   logic [7:0] rd_mux;

   assign idx    = i_wb_adr[9:2];
   assign req    = i_wb_cyc && i_wb_stb && !ack_ff;
   assign wr     = req && i_wb_we && i_wb_sel[0];
   assign wb     = i_wb_dat[7:0];
   assign seq_go   = wr && (idx == wca_pkg::IDX_CONTROL) && wb[wca_pkg::CTL_SEQ_GO];
   assign gen_call = wr && (idx == wca_pkg::IDX_CONTROL) && wb[wca_pkg::CTL_GEN_CALL];
   assign persist  = {1'b0, cnt_ff[7:wca_pkg::CNT_LSB]} + 5'h01;

   // channel 0 thresholds and hysteresis live elsewhere and arrive on ports
   assign cmp0.high_thr = i_ch0_high_thr;
   assign cmp0.low_thr  = i_ch0_low_thr;
   assign cmp0.hyst     = i_ch0_hyst;
   assign cmp0.count    = persist;
   assign cmp0.run      = en_ff[0];
   assign cmp1.high_thr = i_ch1_high_thr;
   assign cmp1.low_thr  = {lth_hi_ff[3:0], lth_lo_ff};
   assign cmp1.hyst     = hys_ff[5:0];
   assign cmp1.count    = persist;
   assign cmp1.run      = en_ff[0];

   wca_channel u_ch0 (
      .i_mclk       (i_mclk),
      .i_rst_n      (i_rst_n),
      .i_ce         (i_ce),
      .i_sample_vld (i_sample_vld && !i_sample_ch),
      .i_sample     (i_sample),
      .cmp          (cmp0.chn)
   );
   wca_channel u_ch1 (
      .i_mclk       (i_mclk),
      .i_rst_n      (i_rst_n),
      .i_ce         (i_ce),
      .i_sample_vld (i_sample_vld && i_sample_ch),
      .i_sample     (i_sample),
      .cmp          (cmp1.chn)
   );

   assign new_low   = {cmp1.low_hit, cmp0.low_hit} & alert_en_ff;
   assign new_high  = {cmp1.high_hit, cmp0.high_hit} & alert_en_ff;
   assign ch_alert  = new_low | new_high;
   assign any_alert = |ch_alert;
   assign irq_ev    = {new_high, new_low};
   assign o_alert   = |(low_flags_ff | high_flags_ff);
   assign o_irq     = |(irq_stat_ff & irq_mask_ff);
   assign o_wb_ack  = ack_ff;
   assign o_wb_dat  = {24'h000000, rdat_ff};

   // reserved bits read as zero by masking on read
   assign rd_mux =
      (idx == wca_pkg::IDX_FIRST_ALERT) ? {chid_ff, 4'h0} :
      (idx == wca_pkg::IDX_LOW_FLAGS)   ? {6'h00, low_flags_ff} :
      (idx == wca_pkg::IDX_HIGH_FLAGS)  ? {6'h00, high_flags_ff} :
      (idx == wca_pkg::IDX_BLOCK_EN)    ? (en_ff & wca_pkg::MASK_EN) :
      (idx == wca_pkg::IDX_ALERT_EN)    ? {6'h00, alert_en_ff} :
      (idx == wca_pkg::IDX_EVENT_COUNT) ? (cnt_ff & wca_pkg::MASK_CNT) :
      (idx == wca_pkg::IDX_CH1_LTH_LO)  ? lth_lo_ff :
      (idx == wca_pkg::IDX_CH1_LTH_HI)  ? (lth_hi_ff & wca_pkg::MASK_LTH_HI) :
      (idx == wca_pkg::IDX_CH1_HYS)     ? (hys_ff & wca_pkg::MASK_HYS) :
      (idx == wca_pkg::IDX_IRQ_STATUS)  ? {4'h0, irq_stat_ff} :
      (idx == wca_pkg::IDX_IRQ_MASK)    ? {4'h0, irq_mask_ff} : 8'h00;

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ack_ff  <= 1'b0;
         rdat_ff <= wca_pkg::RST_BYTE;
      end else if (i_ce) begin
         ack_ff  <= req;
         rdat_ff <= req ? rd_mux : wca_pkg::RST_BYTE;
      end
   end

   // configuration registers; reserved bits are dropped on write
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         lth_lo_ff   <= wca_pkg::RST_BYTE;
         lth_hi_ff   <= wca_pkg::RST_BYTE;
         hys_ff      <= wca_pkg::RST_BYTE;
         cnt_ff      <= wca_pkg::RST_BYTE;
         en_ff       <= wca_pkg::RST_BYTE;
         alert_en_ff <= wca_pkg::RST_ALERT_EN;
         irq_mask_ff <= 4'h0;
      end else if (i_ce && wr) begin
         if (idx == wca_pkg::IDX_CH1_LTH_LO) lth_lo_ff <= wb;
         if (idx == wca_pkg::IDX_CH1_LTH_HI) lth_hi_ff <= wb & wca_pkg::MASK_LTH_HI;
         if (idx == wca_pkg::IDX_CH1_HYS)    hys_ff <= wb & wca_pkg::MASK_HYS;
         if (idx == wca_pkg::IDX_EVENT_COUNT) cnt_ff <= wb & wca_pkg::MASK_CNT;
         if (idx == wca_pkg::IDX_BLOCK_EN)   en_ff <= wb & wca_pkg::MASK_EN;
         if (idx == wca_pkg::IDX_ALERT_EN)   alert_en_ff <= wb[1:0];
         if (idx == wca_pkg::IDX_IRQ_MASK)   irq_mask_ff <= wb[3:0];
      end
   end

   // flags: set wins over write-one-to-clear; general call clears the low and high flags but not irq status
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         low_flags_ff  <= 2'h0;
         high_flags_ff <= 2'h0;
         irq_stat_ff   <= 4'h0;
      end else if (i_ce) begin
         if (gen_call) begin
            low_flags_ff  <= new_low;
            high_flags_ff <= new_high;
         end else begin
            low_flags_ff  <= (low_flags_ff & ~((wr && idx == wca_pkg::IDX_LOW_FLAGS)
                             ? wb[1:0] : 2'h0)) | new_low;
            high_flags_ff <= (high_flags_ff & ~((wr && idx == wca_pkg::IDX_HIGH_FLAGS)
                             ? wb[1:0] : 2'h0)) | new_high;
         end
         irq_stat_ff <= (irq_stat_ff & ~((wr && idx == wca_pkg::IDX_IRQ_STATUS)
                        ? wb[3:0] : 4'h0)) | irq_ev;
      end
   end

   // first-alert record latches once until cleared
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         chid_ff     <= wca_pkg::CHID_CH0;
         chid_set_ff <= 1'b0;
      end else if (i_ce) begin
         if (seq_go || gen_call) begin
            chid_ff     <= wca_pkg::CHID_CH0;
            chid_set_ff <= 1'b0;
         end else if (any_alert && !chid_set_ff) begin
            chid_ff     <= ch_alert[0] ? wca_pkg::CHID_CH0 : wca_pkg::CHID_CH1;
            chid_set_ff <= 1'b1;
         end
      end
   end

   sequence s_ack_after_req;
      req ##1 ack_ff;
   endsequence
   AST_ACK_ONE: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && req |=> ack_ff)
      else $error("ack missing after request");
   AST_ACK_DROP: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      s_ack_after_req |=> !ack_ff || !i_ce)
      else $error("ack held too long");
   AST_LTH_JOIN: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      cmp1.low_thr[11:8] == lth_hi_ff[3:0] && lth_hi_ff[7:4] == 4'h0)
      else $error("threshold join wrong");
   AST_PERSIST: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      cmp0.count == cmp1.count && cmp1.count == {1'b0, cnt_ff[7:4]} + 5'h01)
      else $error("persistence count wrong");
   AST_CHID_RANGE: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      chid_ff[3:1] == 3'h0)
      else $error("illegal channel code");
   AST_CHID_HOLD: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      chid_set_ff && !seq_go && !gen_call |=> $stable(chid_ff))
      else $error("first alert record changed");
   AST_SEQ_CLEAR: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && seq_go |=> chid_ff == 4'h0 && !chid_set_ff)
      else $error("record not cleared");
   AST_FLAG_SET: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && new_low[1] |=> low_flags_ff[1])
      else $error("low flag lost");
   AST_W1C: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && wr && idx == wca_pkg::IDX_HIGH_FLAGS && !gen_call && !new_high[0]
      && wb[0] |=> !high_flags_ff[0])
      else $error("high flag not cleared");
   AST_EN_GATE: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      !alert_en_ff[1] |-> !new_low[1] && !new_high[1])
      else $error("disabled channel alerted");
   AST_RSVD_ZERO: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      hys_ff[7:6] == 2'h0 && cnt_ff[3:0] == 4'h0)
      else $error("reserved bit stored");
endmodule

// File: rtl/wca_pkg.sv
// Purpose: constants for the window comparator alert register bank
// Assumes: classic wishbone, 32-bit data, byte-index offsets scaled by four
// Notes:   register contents are 8 bits wide in the low byte
package wca_pkg;
   localparam logic [7:0] IDX_FIRST_ALERT = 8'h03;
   localparam logic [7:0] IDX_LOW_FLAGS   = 8'h0c;
   localparam logic [7:0] IDX_HIGH_FLAGS  = 8'h0e;
   localparam logic [7:0] IDX_BLOCK_EN    = 8'h30;
   localparam logic [7:0] IDX_ALERT_EN    = 8'h34;
   localparam logic [7:0] IDX_EVENT_COUNT = 8'h36;
   localparam logic [7:0] IDX_CH1_LTH_LO  = 8'h3e;
   localparam logic [7:0] IDX_CH1_LTH_HI  = 8'h3f;
   localparam logic [7:0] IDX_CH1_HYS     = 8'h41;
   localparam logic [7:0] IDX_IRQ_STATUS  = 8'h50;
   localparam logic [7:0] IDX_IRQ_MASK    = 8'h51;
   localparam logic [7:0] IDX_CONTROL     = 8'h52;
   localparam int         CTL_SEQ_GO      = 0;
   localparam int         CTL_GEN_CALL    = 1;
   localparam int         CNT_LSB         = 4;
   localparam int         CHID_LSB        = 4;
   localparam logic [3:0] CHID_CH0        = 4'h0;
   localparam logic [3:0] CHID_CH1        = 4'h1;
   localparam logic [7:0] RST_BYTE        = 8'h00;
   localparam logic [1:0] RST_ALERT_EN    = 2'h0;
   localparam logic [7:0] MASK_LTH_HI     = 8'h0f;
   localparam logic [7:0] MASK_HYS        = 8'h3f;
   localparam logic [7:0] MASK_CNT        = 8'hf0;
   localparam logic [7:0] MASK_FLAGS      = 8'h03;
   localparam logic [7:0] MASK_EN         = 8'h01;
   localparam logic [7:0] MASK_IRQ        = 8'h0f;
endpackage

// File: rtl/wca_cmp_if.sv
// Purpose: carries one channel's comparator settings and results
// Assumes: 12-bit samples
// Notes:   shared count reaches every channel
`timescale 1ns/1ps
interface wca_cmp_if;
   logic [11:0] high_thr;
   logic [11:0] low_thr;
   logic [5:0]  hyst;
   logic [4:0]  count;
   logic        run;
   logic        high_hit;
   logic        low_hit;
   modport ctl (output high_thr, low_thr, hyst, count, run, input high_hit, low_hit);
   modport chn (input high_thr, low_thr, hyst, count, run, output high_hit, low_hit);
endinterface

// File: rtl/wca_channel.sv
// Purpose: one channel of the window comparator with persistence and hysteresis
// Assumes: i_sample_vld marks one conversion result
// Notes:   hit outputs pulse once per confirmed crossing
`timescale 1ns/1ps
module wca_channel (
   input  wire logic        i_mclk,
   input  wire logic        i_rst_n,
   input  wire logic        i_ce,
   input  wire logic        i_sample_vld,
   input  wire logic [11:0] i_sample,
   wca_cmp_if.chn           cmp
);
   logic [4:0]  hi_cnt_ff;
   logic [4:0]  lo_cnt_ff;
   logic        hi_act_ff;
   logic        lo_act_ff;
   logic        hi_hit_ff;
   logic        lo_hit_ff;
   logic [12:0] hi_release;
   logic [12:0] lo_release;
   logic        hi_cond;
   logic        lo_cond;
   logic        hi_rel;
   logic        lo_rel;

   // release points sit hysteresis away from each threshold
   assign hi_release = {1'b0, cmp.high_thr} - {7'h00, cmp.hyst};
   assign lo_release = {1'b0, cmp.low_thr} + {7'h00, cmp.hyst};
   assign hi_cond    = i_sample >= cmp.high_thr;
   assign lo_cond    = i_sample <= cmp.low_thr;
   assign hi_rel     = hi_release[12] || ({1'b0, i_sample} < hi_release);
   assign lo_rel     = {1'b0, i_sample} > lo_release;
   assign cmp.high_hit = hi_hit_ff;
   assign cmp.low_hit  = lo_hit_ff;

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         hi_cnt_ff <= 5'h00;
         lo_cnt_ff <= 5'h00;
         hi_act_ff <= 1'b0;
         lo_act_ff <= 1'b0;
         hi_hit_ff <= 1'b0;
         lo_hit_ff <= 1'b0;
      end else if (i_ce) begin
         hi_hit_ff <= 1'b0;
         lo_hit_ff <= 1'b0;
         if (!cmp.run) begin
            hi_cnt_ff <= 5'h00;
            lo_cnt_ff <= 5'h00;
            hi_act_ff <= 1'b0;
            lo_act_ff <= 1'b0;
         end else if (i_sample_vld) begin
            // consecutive hits are counted; a miss restarts the run
            hi_cnt_ff <= hi_cond ? ((hi_cnt_ff == cmp.count) ? hi_cnt_ff
                                    : hi_cnt_ff + 5'h01) : 5'h00;
            lo_cnt_ff <= lo_cond ? ((lo_cnt_ff == cmp.count) ? lo_cnt_ff
                                    : lo_cnt_ff + 5'h01) : 5'h00;
            if (!hi_act_ff && hi_cond && (hi_cnt_ff + 5'h01 == cmp.count)) begin
               hi_act_ff <= 1'b1;
               hi_hit_ff <= 1'b1;
            end else if (hi_act_ff && hi_rel) begin
               hi_act_ff <= 1'b0;
            end
            if (!lo_act_ff && lo_cond && (lo_cnt_ff + 5'h01 == cmp.count)) begin
               lo_act_ff <= 1'b1;
               lo_hit_ff <= 1'b1;
            end else if (lo_act_ff && lo_rel) begin
               lo_act_ff <= 1'b0;
            end
         end
      end
   end

   AST_HIT_NEEDS_RUN: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      hi_hit_ff |-> $past(cmp.run) && $past(i_sample_vld))
      else $error("high hit without running comparator");
   AST_HIT_ONCE: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && hi_hit_ff |=> !hi_hit_ff)
      else $error("high hit repeated");
endmodule

// File: dv/wca_host_model.sv
// Purpose: host controller model, a classic wishbone master for the register bank
// Assumes: the slave answers every request with one ack; word index scaled by four
// Notes:   released address and data lines are inverted so stale values never match
`timescale 1ns/1ps
module wca_host_model (
   input  wire logic        i_mclk,
   output logic             o_wb_cyc,
   output logic             o_wb_stb,
   output logic             o_wb_we,
   output logic      [31:0] o_wb_adr,
   output logic      [3:0]  o_wb_sel,
   output logic      [31:0] o_wb_dat,
   input  wire logic [31:0] i_wb_dat,
   input  wire logic        i_wb_ack,
   output logic             o_hang
);
   initial begin
      o_wb_cyc = 1'b0;
      o_wb_stb = 1'b0;
      o_wb_we  = 1'b0;
      o_wb_adr = 32'h00000000;
      o_wb_sel = 4'h0;
      o_wb_dat = 32'h00000000;
      o_hang   = 1'b0;
   end
   // one single cycle; read data is taken at the edge that samples ack
   task automatic xfer(input logic we, input logic [7:0] idx, input logic [7:0] wdat,
                       output logic [31:0] rdat);
      int n;
      n = 0;
      @(posedge i_mclk);
      o_wb_cyc <= 1'b1;
      o_wb_stb <= 1'b1;
      o_wb_we  <= we;
      o_wb_sel <= 4'h1;
      o_wb_adr <= {22'h000000, idx, 2'h0};
      o_wb_dat <= {24'h000000, wdat};
      do begin
         @(posedge i_mclk);
         n++;
      end while (i_wb_ack !== 1'b1 && n < 50);
      if (i_wb_ack !== 1'b1) o_hang <= 1'b1;
      rdat = i_wb_dat;
      o_wb_cyc <= 1'b0;
      o_wb_stb <= 1'b0;
      o_wb_we  <= 1'b0;
      o_wb_adr <= ~o_wb_adr;
      o_wb_dat <= ~o_wb_dat;
      @(posedge i_mclk);
   endtask
endmodule

// File: dv/window_comparator_alert_regs_tb.sv
// Purpose: self-checking bench for the window comparator alert register bank
// Assumes: control strobe layout and register indices as the register bank decodes them
// Notes:   persistence count field is set to 1, so two consecutive hits set a flag
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin mismatches++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module window_comparator_alert_regs_tb;
   logic        mclk = 1'b0;
   logic        rst_n = 1'b0;
   logic        cyc, stb, we, ack, alert, irq, hang;
   logic [31:0] adr, wdat, rdat;
   logic [3:0]  sel;
   logic        ce = 1'b1;
   logic        s_vld = 1'b0;
   logic        s_ch = 1'b0;
   logic [11:0] s_val = 12'h000;
   int          mismatches = 0;
   int          tests_run = 0;
   always #20 mclk = ~mclk;
   wca_host_model HOST (.i_mclk(mclk), .o_wb_cyc(cyc), .o_wb_stb(stb), .o_wb_we(we),
      .o_wb_adr(adr), .o_wb_sel(sel), .o_wb_dat(wdat), .i_wb_dat(rdat), .i_wb_ack(ack),
      .o_hang(hang));
   window_comparator_alert_regs DUT (.i_mclk(mclk), .i_rst_n(rst_n), .i_ce(ce),
      .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
      .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_sample_vld(s_vld),
      .i_sample_ch(s_ch), .i_sample(s_val), .i_ch0_high_thr(12'h800),
      .i_ch0_low_thr(12'h000), .i_ch0_hyst(6'h00), .i_ch1_high_thr(12'hfff),
      .o_alert(alert), .o_irq(irq));
   task automatic wr(input logic [7:0] idx, input logic [7:0] val);
      logic [31:0] d;
      HOST.xfer(1'b1, idx, val, d);
   endtask
   task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
      logic [31:0] d;
      HOST.xfer(1'b0, idx, 8'h00, d);
      `CHK(d, {24'h000000, exp})
   endtask
   task automatic smp(input logic ch, input logic [11:0] val);
      @(posedge mclk);
      s_vld <= 1'b1;
      s_ch  <= ch;
      s_val <= val;
      @(posedge mclk);
      s_vld <= 1'b0;
      repeat (3) @(posedge mclk);
   endtask
   task automatic t_reset();
      rd(wca_pkg::IDX_FIRST_ALERT, 8'h00);
      rd(wca_pkg::IDX_LOW_FLAGS, 8'h00);
      rd(wca_pkg::IDX_HIGH_FLAGS, 8'h00);
      rd(wca_pkg::IDX_EVENT_COUNT, 8'h00);
      rd(wca_pkg::IDX_CH1_LTH_LO, 8'h00);
      rd(wca_pkg::IDX_CH1_LTH_HI, 8'h00);
      rd(wca_pkg::IDX_CH1_HYS, 8'h00);
      rd(8'h7f, 8'h00);
      rd(wca_pkg::IDX_BLOCK_EN, 8'h00);
      rd(wca_pkg::IDX_ALERT_EN, 8'h00);
      `CHK({alert, irq}, 2'b00)
      $display("test reset values done");
   endtask
   task automatic t_regs();
      wr(wca_pkg::IDX_CH1_LTH_LO, 8'hff);
      wr(wca_pkg::IDX_CH1_LTH_HI, 8'hff);
      wr(wca_pkg::IDX_CH1_HYS, 8'hff);
      wr(wca_pkg::IDX_EVENT_COUNT, 8'hff);
      wr(wca_pkg::IDX_FIRST_ALERT, 8'hff);
      wr(8'h7f, 8'hff);
      rd(wca_pkg::IDX_CH1_LTH_LO, 8'hff);
      rd(wca_pkg::IDX_CH1_LTH_HI, 8'h0f);
      rd(wca_pkg::IDX_CH1_HYS, 8'h3f);
      rd(wca_pkg::IDX_EVENT_COUNT, 8'hf0);
      rd(wca_pkg::IDX_FIRST_ALERT, 8'h00);
      rd(8'h7f, 8'h00);
      wr(wca_pkg::IDX_CH1_LTH_LO, 8'h23);
      wr(wca_pkg::IDX_CH1_LTH_HI, 8'h01);
      wr(wca_pkg::IDX_CH1_HYS, 8'h00);
      wr(wca_pkg::IDX_EVENT_COUNT, 8'h10);
      $display("test register access done");
   endtask
   task automatic t_persist();
      wr(wca_pkg::IDX_BLOCK_EN, 8'h01);
      wr(wca_pkg::IDX_ALERT_EN, 8'h03);
      smp(1'b1, 12'h123);
      smp(1'b1, 12'h124);
      smp(1'b1, 12'h123);
      rd(wca_pkg::IDX_LOW_FLAGS, 8'h00);
      smp(1'b1, 12'h123);
      rd(wca_pkg::IDX_LOW_FLAGS, 8'h02);
      rd(wca_pkg::IDX_FIRST_ALERT, 8'h10);
      `CHK({alert, irq}, 2'b10)
      rd(wca_pkg::IDX_IRQ_STATUS, 8'h02);
      wr(wca_pkg::IDX_IRQ_MASK, 8'h02);
      `CHK(irq, 1'b1)
      smp(1'b0, 12'h800);
      rd(wca_pkg::IDX_HIGH_FLAGS, 8'h00);
      smp(1'b0, 12'h800);
      rd(wca_pkg::IDX_HIGH_FLAGS, 8'h01);
      rd(wca_pkg::IDX_FIRST_ALERT, 8'h10);
      $display("test persistence and flags done");
   endtask
   task automatic t_clear();
      // flags are cleared only where a one is written; writing zero leaves them set
      wr(wca_pkg::IDX_LOW_FLAGS, 8'h00);
      rd(wca_pkg::IDX_LOW_FLAGS, 8'h02);
      wr(wca_pkg::IDX_HIGH_FLAGS, 8'h01);
      rd(wca_pkg::IDX_HIGH_FLAGS, 8'h00);
      wr(wca_pkg::IDX_LOW_FLAGS, 8'hff);
      rd(wca_pkg::IDX_LOW_FLAGS, 8'h00);
      wr(wca_pkg::IDX_IRQ_STATUS, 8'h0f);
      `CHK({alert, irq}, 2'b00)
      wr(wca_pkg::IDX_CONTROL, 8'h01);
      rd(wca_pkg::IDX_FIRST_ALERT, 8'h00);
      $display("test flag clearing done");
   endtask
   task automatic t_gencall();
      smp(1'b1, 12'h800);
      smp(1'b0, 12'h100);
      smp(1'b1, 12'h000);
      smp(1'b1, 12'h000);
      rd(wca_pkg::IDX_FIRST_ALERT, 8'h10);
      wr(wca_pkg::IDX_CONTROL, 8'h02);
      rd(wca_pkg::IDX_LOW_FLAGS, 8'h00);
      rd(wca_pkg::IDX_FIRST_ALERT, 8'h00);
      smp(1'b1, 12'h800);
      $display("test general call done");
   endtask
   task automatic t_enable();
      wr(wca_pkg::IDX_BLOCK_EN, 8'h00);
      smp(1'b1, 12'h000);
      smp(1'b1, 12'h000);
      rd(wca_pkg::IDX_LOW_FLAGS, 8'h00);
      smp(1'b1, 12'h800);
      wr(wca_pkg::IDX_BLOCK_EN, 8'h01);
      wr(wca_pkg::IDX_ALERT_EN, 8'h01);
      smp(1'b1, 12'h000);
      smp(1'b1, 12'h000);
      rd(wca_pkg::IDX_LOW_FLAGS, 8'h00);
      `CHK(alert, 1'b0)
      $display("test enables done");
   endtask
   task automatic t_hyst();
      // release needs the sample beyond threshold plus hysteresis
      wr(wca_pkg::IDX_ALERT_EN, 8'h03);
      wr(wca_pkg::IDX_CH1_HYS, 8'h10);
      smp(1'b1, 12'h130);
      smp(1'b1, 12'h000);
      smp(1'b1, 12'h000);
      rd(wca_pkg::IDX_LOW_FLAGS, 8'h00);
      smp(1'b1, 12'h134);
      // samples offered while the clock enable is low are not counted
      @(posedge mclk);
      ce <= 1'b0;
      smp(1'b1, 12'h000);
      smp(1'b1, 12'h000);
      @(posedge mclk);
      ce <= 1'b1;
      rd(wca_pkg::IDX_LOW_FLAGS, 8'h00);
      smp(1'b1, 12'h000);
      smp(1'b1, 12'h000);
      rd(wca_pkg::IDX_LOW_FLAGS, 8'h02);
      rd(wca_pkg::IDX_FIRST_ALERT, 8'h10);
      @(posedge mclk);
      rst_n <= 1'b0;
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      rd(wca_pkg::IDX_FIRST_ALERT, 8'h00);
      rd(wca_pkg::IDX_LOW_FLAGS, 8'h00);
      `CHK({alert, irq}, 2'b00)
      $display("test hysteresis, clock enable and reset done");
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   always @(posedge hang) begin
      mismatches++;
      end_sim();
   end
   initial begin
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      t_reset();
      t_regs();
      t_persist();
      t_clear();
      t_gencall();
      t_enable();
      t_hyst();
      end_sim();
   end
endmodule
